// file: hw/qdcd_defines.svh
`ifndef QDCD_DEFINES_SVH
`define QDCD_DEFINES_SVH
// clock and power-on timing
`define QDCD_CLK_PERIOD_NS 10
`define QDCD_POR_TIME_NS 1000
`define QDCD_POR_CYCLES ((`QDCD_POR_TIME_NS + `QDCD_CLK_PERIOD_NS - 1) / `QDCD_CLK_PERIOD_NS)
// command codes of the frame
`define QDCD_CMD_WRITE_INPUT 3'h0
`define QDCD_CMD_UPDATE_DAC 3'h1
`define QDCD_CMD_WRITE_UPD_ALL 3'h2
`define QDCD_CMD_WRITE_UPDATE 3'h3
`define QDCD_CMD_POWER 3'h4
`define QDCD_CMD_RESET 3'h5
`define QDCD_CMD_LOAD_MASK 3'h6
`define QDCD_CMD_REFERENCE 3'h7
// field positions and widths
`define QDCD_CHANNELS 4
`define QDCD_ALL_CHANNELS 3'h7
`define QDCD_SCOPE_BIT 0
`define QDCD_REF_BIT 0
// reset values
`define QDCD_MASK_RESET 4'h0
`define QDCD_PD_RESET 2'h0
`define QDCD_REF_RESET 1'h0
`endif

// file: hw/qdcd_pkg.sv
`include "qdcd_defines.svh"
package qdcd_pkg;
  // command field of a frame
  typedef enum logic [2:0] {
    QDCD_WRITE_INPUT = `QDCD_CMD_WRITE_INPUT,
    QDCD_UPDATE_DAC = `QDCD_CMD_UPDATE_DAC,
    QDCD_WRITE_UPD_ALL = `QDCD_CMD_WRITE_UPD_ALL,
    QDCD_WRITE_UPDATE = `QDCD_CMD_WRITE_UPDATE,
    QDCD_POWER = `QDCD_CMD_POWER,
    QDCD_RESET = `QDCD_CMD_RESET,
    QDCD_LOAD_MASK = `QDCD_CMD_LOAD_MASK,
    QDCD_REFERENCE = `QDCD_CMD_REFERENCE
  } qdcd_cmd_t;
  // output stage modes of a channel
  typedef enum logic [1:0] {
    QDCD_PD_NORMAL = 2'h0,
    QDCD_PD_1K = 2'h1,
    QDCD_PD_100K = 2'h2,
    QDCD_PD_TRISTATE = 2'h3
  } qdcd_pd_t;
  // one 24-bit write frame
  typedef struct packed {
    logic reserved;
    logic spare;
    logic command_bit_2;
    logic command_bit_1;
    logic command_bit_0;
    logic channel_sel_bit_2;
    logic channel_sel_bit_1;
    logic channel_sel_bit_0;
    logic [15:0] data;
  } qdcd_frame_t;
  // low data bits of a power command
  typedef struct packed {
    logic [9:0] unused;
    logic powerdown_mode_hi;
    logic powerdown_mode_lo;
    logic [3:0] channel_en;
  } qdcd_pd_cmd_t;
  // top-level sequencing, one-hot
  typedef enum logic [1:0] {
    QDCD_ST_POR = 2'b01,
    QDCD_ST_RUN = 2'b10
  } qdcd_state_t;
endpackage : qdcd_pkg

// file: hw/qdcd_sync.sv
module qdcd_sync #(
  parameter bit RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level
);
  import qdcd_pkg::*;
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } qdcd_sync_t;
  qdcd_sync_t st;
  qdcd_sync_t next_st;
  // three stages; the level moves only when stages two and three agree
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[1:0], pin};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= {{3{RESET_VAL}}, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign level = st.level;
endmodule : qdcd_sync

// file: hw/qdcd_channel.sv
module qdcd_channel #(
  parameter int unsigned CODE_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [CODE_W-1:0] wr_code,
  input wire logic upd_now,
  input wire logic strobe_low,
  input wire logic sync_mode,
  input wire logic load_en,
  input wire logic [CODE_W-1:0] load_code,
  input wire logic soft_zero,
  output logic [CODE_W-1:0] dac_code
);
  import qdcd_pkg::*;
  typedef struct packed {
    logic [CODE_W-1:0] input_code;
    logic [CODE_W-1:0] dac_code;
    logic pending;
  } qdcd_chan_t;
  qdcd_chan_t st;
  qdcd_chan_t next_st;
  logic [CODE_W-1:0] new_in;
  logic new_pend;
  logic upd;
  // input register, DAC register and the written-since-update flag
  always_comb begin
    next_st = st;
    new_in = wr_en ? wr_code : st.input_code;
    new_pend = st.pending | wr_en;
    upd = upd_now | (wr_en & sync_mode)
      | (strobe_low & ~sync_mode & new_pend);
    if (load_en) begin
      next_st.input_code = load_code;
      next_st.dac_code = load_code;
      next_st.pending = 1'b0;
    end else if (soft_zero) begin
      next_st.dac_code = '0;
      next_st.pending = 1'b0;
    end else begin
      next_st.input_code = new_in;
      next_st.pending = new_pend & ~upd;
      if (upd) begin
        next_st.dac_code = new_in;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dac_code = st.dac_code;
endmodule : qdcd_channel

// file: hw/qdcd_top.sv
module qdcd_top #(
  parameter int unsigned CODE_W = 16,
  parameter bit PIN14 = 1'b1,
  parameter int unsigned POR_CYCLES = `QDCD_POR_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire qdcd_pkg::qdcd_frame_t frame,
  input wire logic frame_valid,
  input wire logic load_strobe_n,
  input wire logic clear_pin_n,
  input wire logic por_level_pin,
  output logic [`QDCD_CHANNELS-1:0][CODE_W-1:0] dac_code,
  output qdcd_pkg::qdcd_pd_t [`QDCD_CHANNELS-1:0] powerdown_mode,
  output logic reference_enable,
  output logic [`QDCD_CHANNELS-1:0] load_mask,
  output logic por_busy
);
  import qdcd_pkg::*;

  localparam int unsigned NCH = `QDCD_CHANNELS;
  localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

  // whole control state of the decoder
  typedef struct packed {
    qdcd_state_t fsm;
    logic [15:0] por_cnt;
    logic [NCH-1:0] load_mask;
    logic [NCH-1:0][1:0] pd;
    logic ref_en;
    logic por_busy;
    logic [23:0] shift_reg;
  } qdcd_top_t;

  qdcd_top_t st;
  qdcd_top_t next_st;

  // decoded fields of the incoming frame
  qdcd_cmd_t cmd;
  logic [2:0] chan_sel;
  qdcd_pd_cmd_t pd_cmd;
  logic [CODE_W-1:0] frame_code;
  logic [NCH-1:0] chan_hit;
  logic frame_ok;

  // synchronised pins
  logic strobe_lvl_n;
  logic clear_lvl_n;
  logic por_lvl;

  // per-channel controls into the register pairs
  logic [NCH-1:0] ch_wr;
  logic [NCH-1:0] ch_upd;
  logic ch_strobe_low;
  logic ch_load;
  logic [CODE_W-1:0] ch_load_code;
  logic ch_soft_zero;
  logic [CODE_W-1:0] midscale;
  logic [CODE_W-1:0] reset_code;
  logic por_done;

  // decode of a channel selector; 111 addresses every channel
  function automatic logic [NCH-1:0] qdcd_chan_decode(input logic [2:0] sel);
    logic [NCH-1:0] hit;
    hit = '0;
    if (sel == `QDCD_ALL_CHANNELS) begin
      hit = '1;
    end else if (sel < 3'(NCH)) begin
      hit[sel[1:0]] = 1'b1;
    end
    return hit;
  endfunction : qdcd_chan_decode

  // pin synchronisers for the strobe, clear and level select
  qdcd_sync #(
    .RESET_VAL(1'b1)
  ) u_sync_strobe (
    .clk(clk),
    .reset_n(reset_n),
    .pin(load_strobe_n),
    .level(strobe_lvl_n)
  );

  qdcd_sync #(
    .RESET_VAL(1'b1)
  ) u_sync_clear (
    .clk(clk),
    .reset_n(reset_n),
    .pin(clear_pin_n),
    .level(clear_lvl_n)
  );

  qdcd_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_por (
    .clk(clk),
    .reset_n(reset_n),
    .pin(por_level_pin),
    .level(por_lvl)
  );

  // frame fields; the frame comes from the framer on this clock
  always_comb begin
    cmd = qdcd_cmd_t'({frame.command_bit_2, frame.command_bit_1, frame.command_bit_0});
    chan_sel = {frame.channel_sel_bit_2, frame.channel_sel_bit_1, frame.channel_sel_bit_0};
    pd_cmd = frame.data;
    frame_code = frame.data[15 -: CODE_W];
    chan_hit = qdcd_chan_decode(chan_sel);
  end

  // frames count only once the power-on window has closed
  assign frame_ok = frame_valid && (st.fsm == QDCD_ST_RUN);

  // power-on reset code: zero on the short variant, pin chosen otherwise
  always_comb begin
    midscale = '0;
    midscale[CODE_W-1] = 1'b1;
    if (PIN14 && por_lvl) begin
      reset_code = midscale;
    end else begin
      reset_code = '0;
    end
  end

  // last cycle of the power-on window
  assign por_done = (st.fsm == QDCD_ST_POR) && (st.por_cnt == POR_LAST);

  // strobe and clear act only outside the power-on window
  always_comb begin
    ch_strobe_low = ~strobe_lvl_n && (st.fsm == QDCD_ST_RUN);
    ch_load = por_done || (~clear_lvl_n && (st.fsm == QDCD_ST_RUN));
    ch_load_code = reset_code;
  end

  // data command strobes into the channel register pairs
  always_comb begin
    ch_wr = '0;
    ch_upd = '0;
    ch_soft_zero = 1'b0;
    if (frame_ok) begin
      case (cmd)
        QDCD_WRITE_INPUT: begin
          ch_wr = chan_hit;
        end
        QDCD_UPDATE_DAC: begin
          ch_upd = chan_hit;
        end
        QDCD_WRITE_UPD_ALL: begin
          ch_wr = chan_hit;
          ch_upd = '1;
        end
        QDCD_WRITE_UPDATE: begin
          ch_wr = chan_hit;
          ch_upd = chan_hit;
        end
        QDCD_RESET: begin
          ch_soft_zero = 1'b1;
        end
        default: begin
          ch_wr = '0;
        end
      endcase
    end
  end

  // one input/DAC register pair per channel
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    qdcd_channel #(
      .CODE_W(CODE_W)
    ) u_chan (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(ch_wr[ch]),
      .wr_code(frame_code),
      .upd_now(ch_upd[ch]),
      .strobe_low(ch_strobe_low),
      .sync_mode(st.load_mask[ch]),
      .load_en(ch_load),
      .load_code(ch_load_code),
      .soft_zero(ch_soft_zero),
      .dac_code(dac_code[ch])
    );
  end

  // sequencing and the control registers
  always_comb begin
    next_st = st;
    if (frame_ok) begin
      next_st.shift_reg = frame;
    end
    case (st.fsm)
      // hold everything while the power-on window runs
      QDCD_ST_POR: begin
        next_st.por_busy = 1'b1;
        next_st.por_cnt = st.por_cnt + 16'h0001;
        if (por_done) begin
          next_st.fsm = QDCD_ST_RUN;
          next_st.por_busy = 1'b0;
          next_st.por_cnt = 16'h0000;
        end
      end
      // decode control commands
      QDCD_ST_RUN: begin
        next_st.por_busy = 1'b0;
        if (frame_ok) begin
          case (cmd)
            QDCD_POWER: begin
              for (int i = 0; i < NCH; i++) begin
                if (pd_cmd.channel_en[i]) begin
                  next_st.pd[i] = {pd_cmd.powerdown_mode_hi, pd_cmd.powerdown_mode_lo};
                end
              end
            end
            QDCD_LOAD_MASK: begin
              next_st.load_mask = frame.data[NCH-1:0];
            end
            QDCD_REFERENCE: begin
              next_st.ref_en = frame.data[`QDCD_REF_BIT];
            end
            QDCD_RESET: begin
              next_st.shift_reg = '0;
              if (frame.data[`QDCD_SCOPE_BIT]) begin
                next_st.load_mask = `QDCD_MASK_RESET;
                next_st.pd = {NCH{`QDCD_PD_RESET}};
                next_st.ref_en = `QDCD_REF_RESET;
              end
            end
            default: begin
              next_st.fsm = QDCD_ST_RUN;
            end
          endcase
        end
      end
      default: begin
        next_st.fsm = QDCD_ST_POR;
        next_st.por_cnt = 16'h0000;
        next_st.por_busy = 1'b1;
      end
    endcase
  end

  // state register; power-on values of every control field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.fsm <= QDCD_ST_POR;
      st.por_cnt <= 16'h0000;
      st.load_mask <= `QDCD_MASK_RESET;
      st.pd <= {NCH{`QDCD_PD_RESET}};
      st.ref_en <= `QDCD_REF_RESET;
      st.por_busy <= 1'b1;
      st.shift_reg <= 24'h000000;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      powerdown_mode[i] = qdcd_pd_t'(st.pd[i]);
    end
    reference_enable = st.ref_en;
    load_mask = st.load_mask;
    por_busy = st.por_busy;
  end

endmodule : qdcd_top

// file: testbench/qdcd_top_assertions.sv
module qdcd_top_assertions
  import qdcd_pkg::*;
#(
  parameter int unsigned CODE_W = 16,
  parameter bit PIN14 = 1'b1,
  parameter int unsigned POR_CYCLES = 100
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire qdcd_pkg::qdcd_frame_t frame,
  input wire logic frame_valid,
  input wire logic load_strobe_n,
  input wire logic clear_pin_n,
  input wire logic por_level_pin,
  input wire logic [3:0][CODE_W-1:0] dac_code,
  input wire qdcd_pkg::qdcd_pd_t [3:0] powerdown_mode,
  input wire logic reference_enable,
  input wire logic [3:0] load_mask,
  input wire logic por_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic quiet;
  logic [2:0] cmd;
  logic [1:0] ch;
  logic [5:0] ld_hist;
  logic [5:0] clr_hist;
  logic [CODE_W-1:0] por_code;
  qdcd_pd_t [3:0] pd_exp;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // decoded frame fields; quiet means both pins idle long enough to pass the sync
  assign cmd = {frame.command_bit_2, frame.command_bit_1, frame.command_bit_0};
  assign ch = {frame.channel_sel_bit_1, frame.channel_sel_bit_0};
  assign take = frame_valid && !por_busy;
  assign quiet = &ld_hist && &clr_hist;
  assign por_code = (PIN14 && por_level_pin) ? CODE_W'(1) << (CODE_W - 1) : '0;
  // power modes a power command should leave
  always_comb begin
    for (int i = 0; i < 4; i++) pd_exp[i] = frame.data[i] ? qdcd_pd_t'(frame.data[5:4]) : powerdown_mode[i];
  end
  // pin history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_hist <= '0;
      clr_hist <= '0;
    end else begin
      ld_hist <= {ld_hist[4:0], load_strobe_n};
      clr_hist <= {clr_hist[4:0], clear_pin_n};
    end
  end
  chk_mask_load: assert property (take && cmd == 3'h6 && quiet |=> load_mask == $past(frame.data[3:0]))
    else $error("load mask wrong");
  chk_ref_set: assert property (take && cmd == 3'h7 && quiet |=> reference_enable == $past(frame.data[0]))
    else $error("reference enable wrong");
  chk_pd_apply: assert property (take && cmd == 3'h4 && quiet |=> powerdown_mode == $past(pd_exp))
    else $error("power mode wrong");
  chk_pd_keeps_code: assert property (take && cmd == 3'h4 && quiet |=> $stable(dac_code))
    else $error("power command moved a code");
  chk_full_reset: assert property (take && cmd == 3'h5 && frame.data[0] && quiet |=>
    load_mask == 4'h0 && !reference_enable && powerdown_mode == '0 && dac_code == '0)
    else $error("full reset incomplete");
  chk_part_reset: assert property (take && cmd == 3'h5 && !frame.data[0] && quiet |=> dac_code == '0 &&
    $stable(load_mask) && $stable(powerdown_mode) && $stable(reference_enable))
    else $error("partial reset wrong");
  chk_por_idle: assert property (por_busy |-> !reference_enable && load_mask == 4'h0 && powerdown_mode == '0)
    else $error("state not at reset in power-on window");
  chk_por_code: assert property ($fell(por_busy) |-> dac_code == {4{por_code}})
    else $error("power-on code wrong");
  chk_sync_update: assert property (take && cmd == 3'h0 && !frame.channel_sel_bit_2 && load_mask[ch] && quiet
    |=> dac_code[$past(ch)] == $past(frame.data[15 -: CODE_W]))
    else $error("masked channel not updated");
  chk_async_hold: assert property (take && cmd == 3'h0 && !frame.channel_sel_bit_2 && !load_mask[ch] && quiet
    |=> $stable(dac_code))
    else $error("code moved without strobe");
  chk_hold_idle: assert property (!frame_valid && !por_busy && quiet |=> $stable(dac_code))
    else $error("code moved while idle");
  cover property (take && cmd == 3'h4);
  cover property ($fell(por_busy));
  cover property (!load_strobe_n && !por_busy);
endmodule : qdcd_top_assertions

bind qdcd_top qdcd_top_assertions #(.CODE_W(CODE_W), .PIN14(PIN14), .POR_CYCLES(POR_CYCLES)) i_qdcd_top_assertions (
  .clk(clk), .reset_n(reset_n), .frame(frame), .frame_valid(frame_valid), .load_strobe_n(load_strobe_n),
  .clear_pin_n(clear_pin_n), .por_level_pin(por_level_pin), .dac_code(dac_code),
  .powerdown_mode(powerdown_mode), .reference_enable(reference_enable), .load_mask(load_mask), .por_busy(por_busy));

// file: testbench/qdcd_host_model.sv
module qdcd_host_model
  import qdcd_pkg::*;
(
  input wire logic clk,
  input wire logic por_busy,
  output qdcd_pkg::qdcd_frame_t frame,
  output logic frame_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame = '0;
    frame_valid = 1'b0;
  end
  // one frame per pulse, never inside the power-on window
  task automatic send(input qdcd_frame_t f);
    wait (!por_busy);
    @(posedge clk);
    frame <= f;
    frame_valid <= 1'b1;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame <= ~f; // no stale frame on an idle bus
  endtask : send
endmodule : qdcd_host_model

// file: testbench/qdcd_top_tb.sv
module qdcd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qdcd_pkg::*;
  typedef struct packed {
    logic [3:0][15:0] dac;
    qdcd_pd_t [3:0] pd;
    logic refe;
    logic [3:0] mask;
  } qdcd_snap_t;
  logic clk, reset_n, frame_valid, load_strobe_n, clear_pin_n, por_level_pin, por_busy, fv_d;
  logic reference_enable;
  logic [3:0] load_mask, pend;
  logic [3:0][15:0] dac_code, inp;
  qdcd_pd_t [3:0] powerdown_mode;
  qdcd_frame_t frame;
  qdcd_snap_t e;
  qdcd_snap_t q[$];
  int n_fail, num_checks;
  qdcd_top #(.POR_CYCLES(20)) i_qdcd_top (.clk(clk), .reset_n(reset_n), .frame(frame),
    .frame_valid(frame_valid), .load_strobe_n(load_strobe_n), .clear_pin_n(clear_pin_n),
    .por_level_pin(por_level_pin), .dac_code(dac_code), .powerdown_mode(powerdown_mode),
    .reference_enable(reference_enable), .load_mask(load_mask), .por_busy(por_busy));
  qdcd_host_model i_qdcd_host_model (.clk(clk), .por_busy(por_busy), .frame(frame), .frame_valid(frame_valid));
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic compare(input qdcd_snap_t exp, input qdcd_snap_t got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : compare
  // model one command, note the expected outputs, then hand the frame to the host
  task automatic cmd(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
    logic hit;
    for (int i = 0; i < 4; i++) begin
      hit = (a == 3'h7) || (a == 3'(i));
      if (hit && !c[2] && c != 3'h1) begin
        inp[i] = d;
        pend[i] = 1'b1;
      end
      if (hit && (c == 3'h1 || c == 3'h3 || c == 3'h0 && e.mask[i]) || c == 3'h2) begin
        e.dac[i] = inp[i];
        pend[i] = 1'b0;
      end
      if (c == 3'h4 && d[i]) e.pd[i] = qdcd_pd_t'(d[5:4]);
      if (c == 3'h5) begin
        e.dac[i] = '0;
        pend[i] = 1'b0;
      end
    end
    if (c == 3'h5 && d[0]) e[60:0] = '0;
    if (c == 3'h6) e.mask = d[3:0];
    if (c == 3'h7) e.refe = d[0];
    q.push_back(e);
    i_qdcd_host_model.send({2'b00, c, a, d});
  endtask : cmd
  // hold the strobe or the clear pin low, then probe with a harmless frame
  task automatic pulse(input bit strobe);
    @(posedge clk);
    if (strobe) load_strobe_n <= 1'b0;
    else clear_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    load_strobe_n <= 1'b1;
    clear_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      if (!strobe) inp[i] = 16'h8000;
      if (!strobe || !e.mask[i] && pend[i]) e.dac[i] = inp[i];
      if (!strobe || !e.mask[i]) pend[i] = 1'b0;
    end
    cmd(3'h7, 3'h0, {15'h0, e.refe});
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare one note after every accepted frame
  always @(posedge clk) fv_d <= frame_valid;
  always @(negedge clk) begin
    if (fv_d === 1'b1 && q.size() > 0) compare(q.pop_front(), {dac_code, powerdown_mode, reference_enable, load_mask});
  end
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
  initial begin
    reset_n = 1'b0;
    load_strobe_n = 1'b1;
    clear_pin_n = 1'b1;
    por_level_pin = 1'b1;
    fv_d = 1'b0;
    e = '0;
    pend = '0;
    void'($urandom(32'hfd0b172d));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    load_strobe_n <= 1'b0;
    clear_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    load_strobe_n <= 1'b1;
    clear_pin_n <= 1'b1;
    e.dac = {4{16'h8000}};
    inp = e.dac;
    cmd(3'h7, 3'h0, 16'h0);
    cmd(3'h6, 3'h5, 16'hFFF4);
    cmd(3'h0, 3'h1, 16'h1234);
    cmd(3'h0, 3'h2, 16'h5678);
    pulse(1'b1);
    for (int m = 0; m < 4; m++) cmd(3'h4, 3'h0, {10'h0, 2'(3 - m), 4'(1 << m)});
    cmd(3'h4, 3'h7, 16'h0001);
    cmd(3'h7, 3'h0, 16'h0001);
    cmd(3'h0, 3'h0, 16'hAAAA);
    cmd(3'h5, 3'h0, 16'hFFFE);
    pulse(1'b1);
    cmd(3'h3, 3'h3, 16'h9999);
    cmd(3'h2, 3'h1, 16'h4321);
    pulse(1'b0);
    repeat (40) cmd(3'($urandom_range(0, 7)), 3'($urandom_range(0, 7)), 16'($urandom));
    cmd(3'h5, 3'h7, 16'h0001);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : qdcd_top_tb
